// file: hw/mbpl_pkg.sv
// constants, types and state for the muxed bus port and latch strobe block
// assumes one clock, mclk, running at twice the crystal input clock rate
// Functional notes
// - strobe high 1.5 of every 4 clocks
// - strobe driven high during reset
// - reduced emission mode suppresses the strobe except during bus accesses
// - low address on port 0 while strobe high
// - port 0 becomes data bus after strobe falls
// - port 0 alternate muxed address/data bus
// - bus does fetch, data read and write
// - bus mode drives highs actively
// - port 0 drivers tri-state on reset
// - port 1 latches reset to one, weak pull-up
// - port 1 latch one also reads as input
// - writing zero holds strong pull-down
// - zero-to-one write pulses strong high driver
// - after pulse pin is output high and input
// - bits 0,1 carry timer 2 signals
// - bits 2,3 carry second serial port
// - bits 4,6 rising-edge interrupts 2 and 4
// - bits 5,7 falling-edge interrupts 3 and 5
// - high address byte presented on port 2
package mbpl_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  // the strobe needs half cycles, so the phase counts half periods of the
  // crystal clock; mclk runs at twice the crystal rate
  localparam int MBPL_HALF_PER_CYCLE = 2;
  localparam int MBPL_STROBE_CYCLES_X2 = 3;
  localparam int MBPL_PERIOD_CYCLES = 4;
  localparam logic [2:0] MBPL_PHASE_LAST = 3'(MBPL_PERIOD_CYCLES * MBPL_HALF_PER_CYCLE - 1);
  localparam logic [2:0] MBPL_STROBE_END = 3'(MBPL_STROBE_CYCLES_X2);
  localparam int MBPL_STRONG_HI_NS = 8;
  localparam int MBPL_CLK_MHZ = 125;
  localparam logic [3:0] MBPL_STRONG_HI_CYCLES =
    4'((MBPL_STRONG_HI_NS * MBPL_CLK_MHZ + 999) / 1000);

  // ----------------------------------------------------------------
  // reset values and pin numbers
  // ----------------------------------------------------------------
  localparam logic [7:0] MBPL_P1_RESET = 8'hff;
  localparam logic [7:0] MBPL_P0_RESET = 8'hff;
  localparam int MBPL_T2_BIT = 0;
  localparam int MBPL_TIMER2_CAPTURE_RELOAD_TRIGGER_BIT = 1;
  localparam int MBPL_RX1_BIT = 2;
  localparam int MBPL_TX1_BIT = 3;

  typedef enum logic [1:0] {
    MBPL_IDLE = 2'b00,
    MBPL_ADDR = 2'b01,
    MBPL_DATA = 2'b10
  } mbpl_bus_t;

  typedef struct packed {
    logic [7:0] p0_out;
    logic [7:0] p0_oe;
    logic [7:0] p2_out;
    logic [7:0] rdata;
    logic rvalid;
  } mbpl_bus_pins_t;

  typedef struct packed {
    logic [2:0] phase;
    logic strobe;
    mbpl_bus_t bus;
    logic [15:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic [7:0] p0_latch;
    logic [7:0] p1_latch;
    logic [31:0] hi_cnt;
    logic [7:0] p0_s1;
    logic [7:0] p0_s2;
    logic [7:0] p1_s1;
    logic [7:0] p1_s2;
    logic [7:0] p1_prev;
    logic [3:0] irq;
    mbpl_bus_pins_t pins;
  } mbpl_state_t;

endpackage : mbpl_pkg

// file: hw/mbpl_port.sv
// port 0 open-drain / muxed bus, port 1 quasi-bidirectional, latch strobe
// assumes mclk at twice the crystal rate and pins synchronised here
`timescale 1ns/1ps
`default_nettype none
module mbpl_port
  import mbpl_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic emi_reduce,
  input wire logic bus_req,
  input wire logic bus_wr,
  input wire logic [15:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  output logic bus_ready,
  output logic [7:0] bus_rdata,
  output logic bus_rvalid,
  input wire logic p0_wr,
  input wire logic [7:0] p0_wdata,
  output logic [7:0] p0_pins_rd,
  input wire logic p1_wr,
  input wire logic [7:0] p1_wdata,
  output logic [7:0] p1_pins_rd,
  input wire logic [7:0] p0_in,
  output logic [7:0] p0_out,
  output logic [7:0] p0_oe,
  output logic [7:0] p2_addr_hi,
  input wire logic [7:0] p1_in,
  output logic [7:0] p1_out,
  output logic [7:0] p1_oe,
  output logic [7:0] p1_weak_pullup,
  output logic addr_latch_strobe,
  input wire logic timer2_out,
  input wire logic timer2_out_en,
  output logic timer2_external_io,
  output logic timer2_capture_reload_trigger,
  output logic serial1_receive_in,
  input wire logic serial1_transmit_out,
  output logic ext_irq2_rising,
  output logic ext_irq3_falling,
  output logic ext_irq4_rising,
  output logic ext_irq5_falling
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  mbpl_state_t s_reg, s_next;
  logic [3:0] hi_cnt_v [8];
  logic [7:0] p1_drv;
  logic [7:0] p1_rise;
  logic [7:0] p1_fall;

  always_comb begin
    s_next = s_reg;
    p1_rise = s_reg.p1_s2 & ~s_reg.p1_prev;
    p1_fall = ~s_reg.p1_s2 & s_reg.p1_prev;
    for (int i = 0; i < 8; i++) begin
      hi_cnt_v[i] = s_reg.hi_cnt[i*4 +: 4];
    end
    // pin synchronisers; first stage read only by second
    s_next.p0_s1 = p0_in;
    s_next.p0_s2 = s_reg.p0_s1;
    s_next.p1_s1 = p1_in;
    s_next.p1_s2 = s_reg.p1_s1;
    s_next.p1_prev = s_reg.p1_s2;
    // edge detectors for the extra interrupt inputs
    s_next.irq = {p1_fall[7], p1_rise[6], p1_fall[5], p1_rise[4]};
    // free-running strobe phase: high for 3 of 8 half cycles
    if (s_reg.phase == MBPL_PHASE_LAST) begin
      s_next.phase = 3'h0;
    end else begin
      s_next.phase = s_reg.phase + 3'h1;
    end
    s_next.pins.rvalid = 1'b0;
    case (s_reg.bus)
      MBPL_IDLE: begin
        if (bus_req && s_reg.phase == MBPL_PHASE_LAST) begin
          s_next.bus = MBPL_ADDR;
          s_next.addr = bus_addr;
          s_next.wr = bus_wr;
          s_next.wdata = bus_wdata;
        end
      end
      MBPL_ADDR: begin
        if (s_reg.phase == MBPL_STROBE_END - 3'h1) begin
          s_next.bus = MBPL_DATA;
        end
      end
      MBPL_DATA: begin
        if (s_reg.phase == MBPL_PHASE_LAST) begin
          s_next.bus = MBPL_IDLE;
          s_next.pins.rvalid = !s_reg.wr;
          s_next.pins.rdata = s_reg.p0_s2;
        end
      end
      default: begin
        s_next.bus = MBPL_IDLE;
      end
    endcase
    // enable decided once per period so emission mode never clips a pulse
    if (s_next.phase == 3'h0) begin
      s_next.strobe = !emi_reduce || s_next.bus != MBPL_IDLE;
    end else begin
      s_next.strobe = s_reg.strobe && (s_next.phase < MBPL_STROBE_END);
    end
    // port 0 pin drive; bus mode drives both levels actively
    case (s_next.bus)
      MBPL_ADDR: begin
        s_next.pins.p0_out = s_next.addr[7:0];
        s_next.pins.p0_oe = 8'hff;
        s_next.pins.p2_out = s_next.addr[15:8];
      end
      MBPL_DATA: begin
        s_next.pins.p0_out = s_next.wdata;
        s_next.pins.p0_oe = s_next.wr ? 8'hff : 8'h00;
        s_next.pins.p2_out = s_next.addr[15:8];
      end
      default: begin
        // open drain: only zeros are driven, board supplies pull-ups
        s_next.pins.p0_out = 8'h00;
        s_next.pins.p0_oe = ~s_reg.p0_latch;
        s_next.pins.p2_out = s_reg.addr[15:8];
      end
    endcase
    if (p0_wr) begin
      s_next.p0_latch = p0_wdata;
    end
    // port 1 latch with a short strong high pulse on a zero-to-one write
    if (p1_wr) begin
      s_next.p1_latch = p1_wdata;
    end
    for (int i = 0; i < 8; i++) begin
      if (p1_wr && p1_wdata[i] && !s_reg.p1_latch[i]) begin
        hi_cnt_v[i] = MBPL_STRONG_HI_CYCLES;
      end else if (hi_cnt_v[i] != 4'h0) begin
        hi_cnt_v[i] = hi_cnt_v[i] - 4'h1;
      end
      s_next.hi_cnt[i*4 +: 4] = hi_cnt_v[i];
    end
    if (sys_rst) begin
      s_next.phase = 3'h0;
      s_next.strobe = 1'b1;
      s_next.bus = MBPL_IDLE;
      s_next.addr = 16'h0000;
      s_next.wdata = 8'h00;
      s_next.wr = 1'b0;
      s_next.p0_latch = MBPL_P0_RESET;
      s_next.p1_latch = MBPL_P1_RESET;
      s_next.hi_cnt = 32'h0000_0000;
      s_next.irq = 4'h0;
      s_next.p1_prev = 8'hff;
      s_next.pins.p0_out = 8'h00;
      s_next.pins.p0_oe = 8'h00;
      s_next.pins.p2_out = 8'h00;
      s_next.pins.rdata = 8'h00;
      s_next.pins.rvalid = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    s_reg <= s_next;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // alternate outputs pull low through the latch path when they idle high
  always_comb begin
    p1_drv = s_reg.p1_latch;
    p1_drv[MBPL_TX1_BIT] = s_reg.p1_latch[MBPL_TX1_BIT] & serial1_transmit_out;
    p1_drv[MBPL_T2_BIT] = s_reg.p1_latch[MBPL_T2_BIT] &
      (!timer2_out_en || timer2_out);
  end

  always_comb begin
    for (int i = 0; i < 8; i++) begin
      p1_out[i] = p1_drv[i];
      p1_oe[i] = !p1_drv[i] || (s_reg.hi_cnt[i*4 +: 4] != 4'h0);
    end
  end

  assign p1_weak_pullup = p1_drv;
  assign addr_latch_strobe = s_reg.strobe;
  assign p0_out = s_reg.pins.p0_out;
  assign p0_oe = s_reg.pins.p0_oe;
  assign p2_addr_hi = s_reg.pins.p2_out;
  assign bus_ready = !sys_rst && s_reg.bus == MBPL_IDLE && s_reg.phase == MBPL_PHASE_LAST;
  assign bus_rdata = s_reg.pins.rdata;
  assign bus_rvalid = s_reg.pins.rvalid;
  assign p0_pins_rd = s_reg.p0_s2;
  assign p1_pins_rd = s_reg.p1_s2;
  assign timer2_external_io = s_reg.p1_s2[MBPL_T2_BIT];
  assign timer2_capture_reload_trigger = s_reg.p1_s2[MBPL_TIMER2_CAPTURE_RELOAD_TRIGGER_BIT];
  assign serial1_receive_in = s_reg.p1_s2[MBPL_RX1_BIT];
  assign ext_irq2_rising = s_reg.irq[0];
  assign ext_irq3_falling = s_reg.irq[1];
  assign ext_irq4_rising = s_reg.irq[2];
  assign ext_irq5_falling = s_reg.irq[3];

endmodule : mbpl_port
`default_nettype wire

// file: verification/mbpl_ext_mem.sv
// external transparent address latch and byte-wide memory on port 0
// assumes the bench resolves port 0 with board pull-ups
`timescale 1ns/1ps
`default_nettype none
module mbpl_ext_mem (
  input wire logic strobe,
  input wire logic rd_en,
  input wire logic [7:0] p0_wire,
  input wire logic [7:0] p0_oe,
  input wire logic [7:0] a_hi,
  output logic [7:0] d_out,
  output logic d_en
);
  logic [7:0] lat;
  logic [7:0] p0_dly;
  // 1 ns hold: the closing strobe edge must beat the new port 0 data
  assign #1 p0_dly = p0_wire;
  // transparent while the strobe is high, holds the low byte after it falls
  always_latch if (strobe) lat <= p0_dly;
  // answers only once the device has let go of port 0
  assign d_en = rd_en && !strobe && p0_oe == 8'h00;
  assign d_out = lat ^ a_hi ^ 8'h5a;
endmodule : mbpl_ext_mem
`default_nettype wire

// file: verification/mbpl_port_sva.sv
// checker for the port 0 bus, latch strobe and edge interrupts
// assumes bind into mbpl_port
`timescale 1ns/1ps
`default_nettype none
module mbpl_sva
  import mbpl_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic bus_req,
  input wire logic bus_wr,
  input wire logic [15:0] bus_addr,
  input wire logic bus_ready,
  input wire logic bus_rvalid,
  input wire logic [7:0] p0_out,
  input wire logic [7:0] p0_oe,
  input wire logic [7:0] p2_addr_hi,
  input wire logic [7:0] p1_in,
  input wire logic [7:0] p1_oe,
  input wire logic addr_latch_strobe,
  input wire logic ext_irq2_rising,
  input wire logic ext_irq3_falling
);
  // ------------------------------------------------------------
  // address captured at the take edge
  // ------------------------------------------------------------
  logic [15:0] ta_reg;
  logic tk;
  assign tk = bus_req && bus_ready;
  always_ff @(posedge mclk) if (tk) ta_reg <= bus_addr;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  a_reset_pins: assert property (disable iff (1'b0) sys_rst |=> addr_latch_strobe &&
    p0_oe == 8'h00 && p1_oe == 8'h00) else $error("pins wrong in reset");
  a_strobe_width: assert property ($rose(addr_latch_strobe) |->
    addr_latch_strobe[*3] ##1 !addr_latch_strobe) else $error("strobe width");
  a_addr_lo: assert property (tk |=> (addr_latch_strobe && p0_oe == 8'hff &&
    p0_out == ta_reg[7:0])[*3]) else $error("low address on port 0");
  a_addr_hi: assert property (tk |=> (p2_addr_hi == ta_reg[15:8])[*8])
    else $error("high address byte");
  a_read_float: assert property (tk && !bus_wr |=> ##3 (p0_oe == 8'h00)[*5])
    else $error("port 0 not released for read");
  a_read_valid: assert property (tk && !bus_wr |-> ##[8:9] bus_rvalid)
    else $error("read answer missing");
  a_irq_rise: assert property ($rose(p1_in[4]) |-> ##[3:4] ext_irq2_rising)
    else $error("rising edge irq missing");
  a_irq_fall: assert property ($fell(p1_in[5]) |-> ##[3:4] ext_irq3_falling)
    else $error("falling edge irq missing");
  c_read: cover property (tk && !bus_wr);
  c_write: cover property (tk && bus_wr);
  c_irq: cover property (ext_irq3_falling);
endmodule : mbpl_sva
bind mbpl_port mbpl_sva i_sva (.*);
`default_nettype wire

// file: verification/mux_bus_port_and_latch_strobe_tb.sv
// testbench for mbpl_port with external latch and memory
// assumes 125 MHz mclk, pull-ups on port 0, external driver on port 1
`timescale 1ns/1ps
`default_nettype none
module mux_bus_port_and_latch_strobe_tb;
  import mbpl_pkg::*;
  logic mclk, sys_rst, emi_reduce, bus_req, bus_wr, bus_ready, bus_rvalid, rd_en, d_en;
  logic [15:0] bus_addr;
  logic [7:0] bus_wdata, bus_rdata, p0_wdata, p0_pins_rd, p1_wdata, p1_pins_rd, d_out;
  logic [7:0] p0_in, p0_out, p0_oe, p2_addr_hi, p1_in, p1_out, p1_oe, p1_weak_pullup, p1x, e;
  logic p0_wr, p1_wr, addr_latch_strobe, timer2_out, timer2_out_en, timer2_external_io;
  logic timer2_capture_reload_trigger, serial1_receive_in, serial1_transmit_out;
  logic ext_irq2_rising, ext_irq3_falling, ext_irq4_rising, ext_irq5_falling;
  int mismatches, checked, cyc, n, x, k;
  mbpl_port i_dut (.*);
  mbpl_ext_mem i_mem (.strobe(addr_latch_strobe), .rd_en(rd_en), .p0_wire(p0_in),
    .p0_oe(p0_oe), .a_hi(p2_addr_hi), .d_out(d_out), .d_en(d_en));
  // ------------------------------------------------------------
  // pin levels, clock, checks
  // ------------------------------------------------------------
  assign p0_in = (p0_out | ~p0_oe) & (d_en ? d_out : 8'hff);
  assign p1_in = (p1_oe & p1_out) | (~p1_oe & p1x);
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      mismatches++;
      test_done();
    end
  end
  task automatic chk(input string nm, input logic [7:0] ex, input logic [7:0] got);
    checked++;
    if (got !== ex) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk
  task automatic test_done();
    if (mismatches == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : test_done
  // request held until the edge where ready is seen
  task automatic acc(input logic w, input logic [15:0] a, input logic [7:0] d);
    {bus_req, bus_wr, bus_addr, bus_wdata, rd_en} = {1'b1, w, a, d, !w};
    n = 0;
    while (bus_ready !== 1'b1 && n < 20) begin
      @(negedge mclk);
      n++;
    end
    @(negedge mclk);
    bus_req = 1'b0;
    if (!w) begin
      n = 0;
      do @(negedge mclk); while (bus_rvalid !== 1'b1 && ++n < 12);
      chk("bus_rdata", a[7:0] ^ a[15:8] ^ 8'h5a, bus_rdata);
    end
    rd_en = 1'b0;
    @(negedge mclk);
  endtask : acc
  task automatic p1w(input logic [7:0] v);
    {p1_wr, p1_wdata} = {1'b1, v};
    @(negedge mclk);
    p1_wr = 1'b0;
  endtask : p1w
  initial begin
    {emi_reduce, bus_req, bus_wr, p0_wr, p1_wr, timer2_out, timer2_out_en, rd_en} = '0;
    {bus_addr, bus_wdata, p0_wdata, p1_wdata, serial1_transmit_out, sys_rst} = '1;
    p1x = 8'hff;
    void'($urandom(32'h4ddea577));
    repeat (3) @(negedge mclk);
    chk("reset pins", 8'h01, {7'h0, addr_latch_strobe} | p0_oe | p1_oe);
    chk("p1_weak_pullup", 8'hff, p1_weak_pullup);
    sys_rst = 1'b0;
    acc(1'b0, 16'hffff, 8'h00);
    acc(1'b0, 16'h0000, 8'h00);
    for (k = 0; k < 12; k++) begin
      emi_reduce = k > 5;
      acc(k[0], 16'($urandom()), 8'($urandom()));
    end
    repeat (16) @(negedge mclk);
    for (k = 0; k < 2; k++) begin
      n = 0;
      repeat (24) @(negedge mclk) n += addr_latch_strobe;
      chk("strobe highs", k ? 8'h09 : 8'h00, 8'(n));
      emi_reduce = 1'b0;
      repeat (8) @(negedge mclk);
    end
    p1w(8'h00);
    chk("p1 strong low", 8'hff, p1_oe & ~p1_out);
    repeat (3) @(negedge mclk);
    chk("p1 low held", 8'hff, p1_oe & ~p1_out);
    p1w(8'hff);
    chk("p1 strong high", 8'hff, p1_oe & p1_out);
    @(negedge mclk);
    chk("p1 weak high", 8'hff, ~p1_oe & p1_weak_pullup);
    repeat (6) @(negedge mclk);
    for (k = 0; k < 16; k++) begin
      e = p1x;
      p1x = (k == 0) ? 8'h30 : 8'($urandom());
      x = (p1x[4] & ~e[4]) + (e[5] & ~p1x[5]) + (p1x[6] & ~e[6]) + (e[7] & ~p1x[7]);
      n = 0;
      repeat (7) @(negedge mclk)
        n += ext_irq2_rising + ext_irq3_falling + ext_irq4_rising + ext_irq5_falling;
      chk("irq pulses", 8'(x), 8'(n));
      chk("p1_pins_rd", p1x, p1_pins_rd);
      chk("p1 alt inputs", {5'h0, p1x[2:0]}, {5'h0, serial1_receive_in,
        timer2_capture_reload_trigger, timer2_external_io});
    end
    {serial1_transmit_out, timer2_out_en, timer2_out} = 3'b010;
    @(negedge mclk);
    chk("p1 alt outputs", 8'h09, p1_oe & ~p1_out & 8'h09);
    e = 8'($urandom());
    {p0_wr, p0_wdata} = {1'b1, e};
    @(negedge mclk);
    p0_wr = 1'b0;
    repeat (4) @(negedge mclk);
    chk("p0_pins_rd", e, p0_pins_rd);
    test_done();
  end
endmodule : mux_bus_port_and_latch_strobe_tb
`default_nettype wire
